/* design/config_startup_sequencer.v */
/*
 * startup sequencer with APB register access; steps phases 0..7 after start.
 * assumes config_clock drives core_clk and is kept running until done (RQ9).
 */
`default_nettype none
`include "startup_consts.vh"

module config_startup_sequencer (
	input wire core_clk,
	input wire sys_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire clock_manager_locked,
	input wire impedance_calibration_matched,
	input wire readback_req,
	output reg done_out,
	output reg global_tristate_hold,
	output reg global_write_enable,
	output reg bram_enable,
	output reg global_high_hold,
	output reg global_set_reset,
	output reg readback_allowed,
	output reg internal_config_port_top,
	output reg internal_config_port_bottom
);

// ==========================================
// registers
reg [7:0] ctrl_r;
reg [31:0] phase_r;
reg [2:0] phase_cnt_r;
reg running_r;
reg done_pipe_r;
reg finished_r;

// a finished run may be restarted; only a run in progress locks the options
wire busy = running_r & ~finished_r;
wire acc = psel & penable;
wire wr = acc & pwrite;
wire hit = (paddr == `REG_CTRL) | (paddr == `REG_PHASE) | (paddr == `REG_STATUS);
assign pready = 1'b1;
assign pslverr = acc & ~hit;

wire [3:0] done_sel = phase_r[`PH_DONE_LO +: 4];
wire [3:0] tri_sel = phase_r[`PH_TRI_LO +: 4];
wire [3:0] we_sel = phase_r[`PH_WE_LO +: 4];
wire [3:0] lock_sel = phase_r[`PH_LOCK_LO +: 4];
wire [3:0] match_raw = phase_r[`PH_MATCH_LO +: 4];
wire [1:0] sec = ctrl_r[`CTRL_SEC_HI:`CTRL_SEC_LO];
wire [1:0] port_sel = ctrl_r[`CTRL_PORT_HI:`CTRL_PORT_LO];

// auto match: phase 2 with calibrated io, else no wait
wire [3:0] match_sel = (match_raw == `SEL_AUTO) ?
	(ctrl_r[`CTRL_IMP_USED] ? 4'h2 : `SEL_NOWAIT) : match_raw; // RQ8

wire [3:0] cur = {1'b0, phase_cnt_r};
wire lock_stall = (lock_sel != `SEL_NOWAIT) && (lock_sel == cur) && !clock_manager_locked; // RQ6
wire match_stall = (match_sel != `SEL_NOWAIT) && (match_sel == cur) && !impedance_calibration_matched; // RQ7
wire stall = lock_stall | match_stall;

// done phase reached (keep never fires)
wire done_hit = running_r && (done_sel != `SEL_KEEP) && (cur >= done_sel); // RQ1
// done pipeline adds one registered stage
wire done_now = ctrl_r[`CTRL_DONE_PIPE] ? done_pipe_r : done_hit; // RQ2

// a selector of "done" follows the done output, keep holds forever
function phase_hit;
	input [3:0] sel;
	input [3:0] ph;
	input run;
	input dn;
	begin
		if (sel == `SEL_KEEP)
			phase_hit = 1'b0;
		else if (sel == `SEL_DONE)
			phase_hit = dn;
		else
			phase_hit = run && (ph >= sel);
	end
endfunction

wire tri_rel = phase_hit(tri_sel, cur, running_r, done_now); // RQ3
wire we_on = phase_hit(we_sel, cur, running_r, done_now); // RQ4

// ==========================================
// sequencer
always @(posedge core_clk) begin
	if (sys_rst) begin
		phase_cnt_r <= 3'h0;
		running_r <= 1'b0;
		done_pipe_r <= 1'b0;
		finished_r <= 1'b0;
	end else begin
		done_pipe_r <= done_hit;
		if (wr && paddr == `REG_CTRL && pwdata[`CTRL_START] && !busy) begin
			running_r <= 1'b1;
			phase_cnt_r <= 3'h0;
			finished_r <= 1'b0;
		end else if (running_r && !stall && phase_cnt_r != `LAST_PHASE) begin
			phase_cnt_r <= phase_cnt_r + 3'h1; // RQ13
		end else if (running_r && phase_cnt_r == `LAST_PHASE) begin
			finished_r <= 1'b1;
		end
	end
end

// ==========================================
// outputs
always @(posedge core_clk) begin
	if (sys_rst) begin
		done_out <= 1'b0;
		global_tristate_hold <= 1'b1;
		global_write_enable <= 1'b0;
		bram_enable <= 1'b0;
		global_high_hold <= 1'b0;
		global_set_reset <= 1'b0;
		readback_allowed <= 1'b0;
		internal_config_port_top <= 1'b0;
		internal_config_port_bottom <= 1'b0;
	end else begin
		done_out <= done_now;
		global_tristate_hold <= !tri_rel;
		global_write_enable <= we_on;
		bram_enable <= we_on; // RQ5
		// hold and reset only while configuring, never in active reconfig
		global_high_hold <= running_r && !we_on && !ctrl_r[`CTRL_ACTIVE_RECFG]; // RQ10
		global_set_reset <= running_r && !we_on && !ctrl_r[`CTRL_ACTIVE_RECFG]; // RQ10
		readback_allowed <= readback_req && (sec == `SEC_NONE); // RQ11
		// auto picks the top port; bottom only when asked for
		internal_config_port_top <= readback_req && (sec == `SEC_NONE) &&
			(port_sel != `PORT_BOTTOM); // RQ12
		internal_config_port_bottom <= readback_req && (sec == `SEC_NONE) &&
			(port_sel == `PORT_BOTTOM); // RQ12
	end
end

// ==========================================
// apb registers
always @(posedge core_clk) begin
	if (sys_rst) begin
		ctrl_r <= 8'h00;
		phase_r <= `PHASE_RST;
	end else if (wr && !busy) begin
		// options frozen while sequencing to avoid mid-run glitches
		if (paddr == `REG_CTRL)
			ctrl_r <= {pwdata[7:1], 1'b0};
		if (paddr == `REG_PHASE)
			phase_r <= {12'h000, pwdata[19:0]};
	end
end

always @(posedge core_clk) begin
	if (sys_rst) begin
		prdata <= 32'h0000_0000;
	end else if (psel && !penable && !pwrite) begin
		case (paddr)
			`REG_CTRL: prdata <= {24'h000000, ctrl_r};
			`REG_PHASE: prdata <= phase_r;
			`REG_STATUS: prdata <= {25'h0, finished_r, done_out, running_r, stall, phase_cnt_r};
			default: prdata <= 32'h0000_0000;
		endcase
	end
end

endmodule
`default_nettype wire

/* design/startup_consts.vh */
/*
 * constants for the configuration startup sequencer: phase numbers,
 * option encodings, APB register map and field positions.
 * assumes inclusion by the sequencer module and the bench.
 */
// What this block does
// RQ1: done output asserts in selectable phase, default 4, or keep.
// RQ2: done pipeline option delays done beyond its selected phase.
// RQ3: tristate hold released in selectable phase, default 5, done or keep.
// RQ4: global write enable asserted in selectable phase, default 6, done or keep.
// RQ5: block RAM access disabled until write enable phase, enabled afterwards.
// RQ6: optional lock-wait phase 0..6 stalls until all clock managers lock.
// RQ7: optional match phase stalls until impedance match asserts.
// RQ8: automatic match setting resolves to phase 2 if calibrated I/O used, else none.
// RQ9: configuration source keeps toggling clock until done seen high.
// RQ10: active reconfig option suppresses global high hold and set/reset.
// RQ11: first readback security level refuses readback; none permits it.
// RQ12: readback routed via top or bottom port as selected, auto default.
// RQ13: at most one phase step per cycle, only with no pending stall.
`ifndef STARTUP_CONSTS_VH
`define STARTUP_CONSTS_VH

// ==========================================
// phase selector encodings (4 bits)
`define SEL_W 4
`define SEL_DONE 4'h7
`define SEL_KEEP 4'h8
`define SEL_NOWAIT 4'hF
`define SEL_AUTO 4'hE
`define LAST_PHASE 3'h7

// ==========================================
// register byte offsets
`define REG_CTRL 12'h000
`define REG_PHASE 12'h004
`define REG_STATUS 12'h008

// ==========================================
// ctrl fields
`define CTRL_START 0
`define CTRL_DONE_PIPE 1
`define CTRL_ACTIVE_RECFG 2
`define CTRL_SEC_LO 3
`define CTRL_SEC_HI 4
`define CTRL_PORT_LO 5
`define CTRL_PORT_HI 6
`define CTRL_IMP_USED 7

// phase register nibbles
`define PH_DONE_LO 0
`define PH_TRI_LO 4
`define PH_WE_LO 8
`define PH_LOCK_LO 12
`define PH_MATCH_LO 16
`define PHASE_RST 32'h000E_F654

// readback security and port encodings
`define SEC_NONE 2'h0
`define SEC_READBACK_BLOCK_LEVEL 2'h1
`define PORT_AUTO 2'h0
`define PORT_TOP 2'h1
`define PORT_BOTTOM 2'h2

`endif

/* testbench/config_source_model.sv */
/* far side: lock and match levels.
assumes commands from the bench. */
`default_nettype none
// ====
module config_source_model(input wire logic core_clk, input wire logic lock_go, input wire logic match_go,
	output logic clock_manager_locked = 1'b0, output logic impedance_calibration_matched = 1'b0);
	// slow on purpose: levels lag the command by a clock
	always @(posedge core_clk) begin
		clock_manager_locked <= lock_go;
		impedance_calibration_matched <= match_go;
	end
endmodule
`default_nettype wire

/* testbench/config_startup_sequencer_props.sv */
/* checker of the sequencer ports.
assumes bind into the sequencer top. */
`default_nettype none
// ====
module config_startup_sequencer_props(input wire logic core_clk, sys_rst, psel, penable, pready, pslverr,
	readback_req, done_out, global_tristate_hold, global_write_enable, bram_enable, global_high_hold,
	global_set_reset, readback_allowed, internal_config_port_top, internal_config_port_bottom);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_acc; psel && penable; endsequence
	AST_RST: assert property ($fell(sys_rst) |-> global_tristate_hold && !done_out) else $error("reset state");
	AST_BRAM: assert property (bram_enable == global_write_enable) else $error("bram gate");
	AST_HOLD: assert property (global_high_hold |-> global_set_reset && !global_write_enable) else $error("hold");
	AST_PORT: assert property (!(internal_config_port_top && internal_config_port_bottom)) else $error("port");
	AST_RB: assert property (readback_allowed |-> $past(readback_req)) else $error("readback");
	AST_DONE: assert property ($rose(done_out) |=> done_out [*2]) else $error("done dropped");
	AST_SLV: assert property (pslverr |-> s_acc) else $error("slverr");
	AST_RDY: assert property (s_acc |-> pready) else $error("ready");
endmodule
bind config_startup_sequencer config_startup_sequencer_props u_config_startup_sequencer_props(.core_clk(core_clk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.readback_req(readback_req), .done_out(done_out), .global_tristate_hold(global_tristate_hold),
	.global_write_enable(global_write_enable), .bram_enable(bram_enable), .global_high_hold(global_high_hold),
	.global_set_reset(global_set_reset), .readback_allowed(readback_allowed),
	.internal_config_port_top(internal_config_port_top), .internal_config_port_bottom(internal_config_port_bottom));
`default_nettype wire

/* testbench/config_startup_sequencer_tb.sv */
/* bench: table rows, then stall, refusal, bus cases.
assumes the constants header on the path. */
`default_nettype none
`include "startup_consts.vh"
// ====
module config_startup_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, readback_req = 0, lock_go = 0, match_go = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, lk, mt, done_out, global_tristate_hold, global_write_enable, bram_enable;
	logic global_high_hold, global_set_reset, readback_allowed, internal_config_port_top, internal_config_port_bottom;
	int bad_count = 0, cmp_count = 0, cyc = 0;
	// ctrl, phase, {done, hold, we, readback, bottom}
	logic [44:0] rows [5] = '{{8'h01, 32'h000EF654, 5'h16}, {8'h09, 32'h000EF658, 5'h04},
		{8'h41, 32'h000EF884, 5'h1B}, {8'h03, 32'h000EF774, 5'h16}, {8'h81, 32'h000E3654, 5'h16}};
	always #5 core_clk = ~core_clk;
	config_source_model u_config_source_model(.core_clk(core_clk), .lock_go(lock_go), .match_go(match_go),
		.clock_manager_locked(lk), .impedance_calibration_matched(mt));
	config_startup_sequencer u_config_startup_sequencer(.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clock_manager_locked(lk), .impedance_calibration_matched(mt),
		.readback_req(readback_req), .done_out(done_out), .global_tristate_hold(global_tristate_hold),
		.global_write_enable(global_write_enable), .bram_enable(bram_enable), .global_high_hold(global_high_hold),
		.global_set_reset(global_set_reset), .readback_allowed(readback_allowed),
		.internal_config_port_top(internal_config_port_top),
		.internal_config_port_bottom(internal_config_port_bottom));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// bounded wait on one status bit
	task automatic poll(input int b);
		repeat (40) begin
			apb(1'b0, `REG_STATUS, 32'h0);
			if (rd[b] === 1'b1) return;
		end
		bad_count++;
	endtask
	task automatic go(input logic [7:0] c, input logic [31:0] p);
		apb(1'b1, `REG_PHASE, p);
		apb(1'b1, `REG_CTRL, {24'h0, c});
	endtask
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run;
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0; readback_req <= 1'b1; lock_go <= 1'b1; match_go <= 1'b1;
		apb(1'b0, `REG_PHASE, 32'h0);
		chk(rd, `PHASE_RST);
		chk(32'(global_tristate_hold), 32'h1);
		$display("reset test end");
		foreach (rows[i]) begin
			go(rows[i][44:37], rows[i][36:5]);
			poll(6);
			chk(32'({done_out, global_tristate_hold, global_write_enable, readback_allowed,
				internal_config_port_bottom}), 32'(rows[i][4:0]));
			$display("row %0d end", i);
		end
		lock_go <= 1'b0;
		go(8'h05, 32'h000E3654);
		poll(3);
		chk(rd, 32'h1B);
		chk(32'({global_high_hold, global_set_reset, done_out}), 32'h0);
		apb(1'b1, `REG_PHASE, 32'h0);
		apb(1'b0, `REG_PHASE, 32'h0);
		chk(rd, 32'h000E3654);
		lock_go <= 1'b1;
		poll(6);
		$display("lock stall end");
		match_go <= 1'b0;
		go(8'h81, `PHASE_RST);
		poll(3);
		chk(rd, 32'h1A);
		chk(32'({global_high_hold, global_set_reset, bram_enable, internal_config_port_top}), 32'hD);
		match_go <= 1'b1;
		poll(6);
		$display("match stall end");
		go(8'h01, `PHASE_RST);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		chk(32'({done_out, global_tristate_hold, global_write_enable}), 32'h2);
		apb(1'b0, `REG_STATUS, 32'h0);
		chk(rd, 32'h0);
		$display("mid reset end");
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		$display("bus test end");
		complete_run;
	end
endmodule
`default_nettype wire
